//--- hw/irq_ctrl_defines.svh
// offsets, field positions, reset values and codes of the interrupt controller
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

`define OFS_EDGE_SEL_A   12'h000
`define OFS_EDGE_SEL_B   12'h004
`define OFS_IRQ_EN_A     12'h008
`define OFS_IRQ_EN_B     12'h00C
`define OFS_IRQ_PEND_A   12'h010
`define OFS_IRQ_PEND_B   12'h014
`define OFS_CORE_CTRL    12'h018

`define NIB_RESET        4'h0
`define EDGE_NONE        2'b00
`define EDGE_FALL        2'b01
`define EDGE_RISE        2'b10
`define EDGE_BOTH        2'b11

`define FLD_PIN_ZERO_EDGE 1:0
`define FLD_PIN_ONE_EDGE  3:2
`define FLD_KEYSCAN_EDGE  1:0

`define CTRL_MASK_BIT    0
`define CTRL_DEPTH_LSB   4
`define STATUS_MASK_BIT  3
`define STACK_DEPTH      8
`define SRC_COUNT        8

`endif

//--- hw/irq_ctrl_pkg.sv
// types shared by the interrupt controller
package irq_ctrl_pkg;
    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_PRE = 1'b1
    } entry_state_e;

    typedef logic [3:0] nibble_t;
endpackage

//--- hw/nibble_mcu_interrupt_ctrl.sv
// interrupt controller: edge detect, flags, priority, vector and state stacks
`timescale 1ns/100ps
`include "irq_ctrl_defines.svh"

// Contract
// RULE1 - mask flag zero blocks all maskable requests
// RULE2 - mask set: accept only individually enabled sources
// RULE3 - request flag set on active edge
// RULE4 - accepted flag cleared automatically at entry
// RULE5 - flag holds until accepted or cleared
// RULE6 - reset clears both request flag registers
// RULE7 - software reads and writes all interrupt registers
// RULE8 - edge field: 01 fall, 10 rise, 11 both
// RULE9 - enable a: timer1, timer0, pin one, zero
// RULE10 - enable b: watchdog, voltage, key scan, converter
// RULE11 - pending a: timer1, timer0, pin one, zero
// RULE12 - pending b: watchdog, voltage, key scan, converter
// RULE13 - sampling delay zero to two machine cycles
// RULE14 - exactly one machine cycle of preprocessing
// RULE15 - mask instruction effect immediate after completion
// RULE16 - entry clears global mask flag
// RULE17 - mask set instruction sets flag, allows nesting
// RULE18 - simultaneous requests: highest priority only accepted
// RULE19 - push counter and flags, 8-level stacks
// RULE20 - vector loaded in same cycle as save
// RULE21 - fixed priority and vectors 0002h to 0010h
// RULE22 - nesting supported up to eight levels
// RULE23 - pins pass two-stage synchroniser before detect
// RULE24 - hardware set beats simultaneous software clear
module nibble_mcu_interrupt_ctrl #(
    parameter int PC_W   = 12,
    parameter int FLAG_W = 4
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 ext_pin_zero,
    input  wire logic                 ext_pin_one,
    input  wire logic                 key_scan_input,
    input  wire logic                 timer_zero_event,
    input  wire logic                 timer_one_event,
    input  wire logic                 converter_event,
    input  wire logic                 voltage_level_alarm,
    input  wire logic                 watchdog,
    input  wire logic                 machine_cycle,
    input  wire logic                 mask_set_instr,
    input  wire logic                 mask_clear_instr,
    input  wire logic                 return_instr,
    input  wire logic [PC_W-1:0]      core_pc,
    input  wire logic [FLAG_W-1:0]    status_flag_reg,
    output logic                      vector_load,
    output logic      [PC_W-1:0]      vector_addr,
    output logic                      preprocess_busy,
    output logic                      restore_load,
    output logic      [PC_W-1:0]      restore_pc,
    output logic      [FLAG_W-1:0]    restore_flags,
    output logic                      global_mask,
    output logic                      stack_overflow
);
    import irq_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // sel bit0 = falling, bit1 = rising
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        edge_hit = (sel[0] & prev & ~cur) | (sel[1] & ~prev & cur); // RULE8
    endfunction

    // bit 0 is the highest priority source
    function automatic logic [2:0] top_source(input logic [7:0] req);
        top_source = 3'h0;
        for (int i = `SRC_COUNT - 1; i >= 0; i--) begin
            if (req[i]) begin
                top_source = 3'(i); // RULE18
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection

    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic [2:0] pin_prev_reg;
    logic [4:0] evt_prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            pin_prev_reg <= 3'h0;
            evt_prev_reg <= 5'h0;
        end else begin
            pin_meta_reg <= {key_scan_input, ext_pin_one, ext_pin_zero}; // RULE23
            pin_sync_reg <= pin_meta_reg; // RULE23
            pin_prev_reg <= pin_sync_reg;
            // internal sources are same-clock logic; a held level counts once
            evt_prev_reg <= {watchdog, voltage_level_alarm, converter_event,
                             timer_one_event, timer_zero_event};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    nibble_t edge_sel_a_reg;
    nibble_t edge_sel_b_reg;
    nibble_t irq_enable_a_reg;
    nibble_t irq_enable_b_reg;
    nibble_t irq_pending_a_reg;
    nibble_t irq_pending_b_reg;
    logic    mask_reg;
    logic        wr_en;
    logic        rd_en;
    logic        addr_hit;
    logic [7:0]  hw_set;
    logic [7:0]  accept_clr;
    logic [7:0]  pend_all;
    logic [7:0]  eligible;
    logic [2:0]  winner;
    logic        take;
    logic [31:0] rd_word;
    logic [3:0]  stack_count;
    assign wr_en = psel & penable & pready & pwrite;
    assign rd_en = psel & penable & ~pready;

    always_comb begin
        hw_set[0] = edge_hit(edge_sel_a_reg[`FLD_PIN_ZERO_EDGE], pin_prev_reg[0],
                             pin_sync_reg[0]); // RULE3
        hw_set[1] = edge_hit(edge_sel_a_reg[`FLD_PIN_ONE_EDGE], pin_prev_reg[1],
                             pin_sync_reg[1]); // RULE3
        hw_set[2] = timer_zero_event & ~evt_prev_reg[0]; // RULE3
        hw_set[3] = timer_one_event & ~evt_prev_reg[1];
        hw_set[4] = converter_event & ~evt_prev_reg[2];
        hw_set[5] = edge_hit(edge_sel_b_reg[`FLD_KEYSCAN_EDGE], pin_prev_reg[2],
                             pin_sync_reg[2]); // RULE3
        hw_set[6] = voltage_level_alarm & ~evt_prev_reg[3];
        hw_set[7] = watchdog & ~evt_prev_reg[4];
    end

    // pending bits line up with priority order: a[0..3], then b[0..3]
    assign pend_all = {irq_pending_b_reg, irq_pending_a_reg}; // RULE21
    assign eligible = pend_all & {irq_enable_b_reg, irq_enable_a_reg}
                      & {8{mask_reg}}; // RULE1 RULE2
    assign winner   = top_source(eligible); // RULE18
    // sampling only at a machine cycle boundary the core reports
    assign take     = machine_cycle & (|eligible) & ~preprocess_busy; // RULE13

    always_comb begin
        accept_clr = 8'h00;
        if (take) begin
            accept_clr[winner] = 1'b1; // RULE4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sel_a_reg   <= `NIB_RESET;
            edge_sel_b_reg   <= `NIB_RESET;
            irq_enable_a_reg <= `NIB_RESET;
            irq_enable_b_reg <= `NIB_RESET;
        end else if (wr_en) begin
            if (paddr == `OFS_EDGE_SEL_A) begin
                edge_sel_a_reg <= pwdata[3:0]; // RULE7
            end else if (paddr == `OFS_EDGE_SEL_B) begin
                edge_sel_b_reg <= pwdata[3:0];
            end else if (paddr == `OFS_IRQ_EN_A) begin
                irq_enable_a_reg <= pwdata[3:0]; // RULE9
            end else if (paddr == `OFS_IRQ_EN_B) begin
                irq_enable_b_reg <= pwdata[3:0]; // RULE10
            end
        end
    end

    // software write, then acceptance clear, then hardware set on top
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pending_a_reg <= `NIB_RESET; // RULE6
            irq_pending_b_reg <= `NIB_RESET; // RULE6
        end else begin
            irq_pending_a_reg <= (((wr_en && paddr == `OFS_IRQ_PEND_A) ? pwdata[3:0]
                                  : irq_pending_a_reg) & ~accept_clr[3:0])
                                 | hw_set[3:0]; // RULE5 RULE11 RULE24
            irq_pending_b_reg <= (((wr_en && paddr == `OFS_IRQ_PEND_B) ? pwdata[3:0]
                                  : irq_pending_b_reg) & ~accept_clr[7:4])
                                 | hw_set[7:4]; // RULE5 RULE12 RULE24
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // global mask flag

    logic [FLAG_W-1:0] pop_flags;
    // entry wins over an instruction in the same cycle; that cannot occur
    // in practice as the core does not retire while taking an entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= 1'b0;
        end else if (take) begin
            mask_reg <= 1'b0; // RULE16
        end else if (mask_set_instr) begin
            mask_reg <= 1'b1; // RULE15 RULE17
        end else if (mask_clear_instr) begin
            mask_reg <= 1'b0; // RULE15
        end else if (return_instr && stack_count != 4'h0) begin
            mask_reg <= pop_flags[`STATUS_MASK_BIT];
        end else if (wr_en && paddr == `OFS_CORE_CTRL) begin
            mask_reg <= pwdata[`CTRL_MASK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // return and flag stacks

    logic [PC_W-1:0]   pc_stack   [`STACK_DEPTH];
    logic [FLAG_W-1:0] flag_stack [`STACK_DEPTH];
    logic [2:0]        top_idx;
    logic [FLAG_W-1:0] push_flags;

    assign top_idx   = 3'(stack_count - 4'h1);
    assign pop_flags = flag_stack[top_idx];

    always_comb begin
        push_flags = status_flag_reg;
        push_flags[`STATUS_MASK_BIT] = mask_reg;
    end

    // a ninth push overwrites the newest (top) entry and raises overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_count <= 4'h0;
            for (int i = 0; i < `STACK_DEPTH; i++) begin
                pc_stack[i]   <= '0;
                flag_stack[i] <= '0;
            end
        end else if (take) begin
            if (stack_count == 4'(`STACK_DEPTH)) begin
                pc_stack[`STACK_DEPTH-1]   <= core_pc;
                flag_stack[`STACK_DEPTH-1] <= push_flags;
            end else begin
                pc_stack[stack_count[2:0]]   <= core_pc; // RULE19
                flag_stack[stack_count[2:0]] <= push_flags; // RULE19
                stack_count                  <= stack_count + 4'h1; // RULE22
            end
        end else if (return_instr && stack_count != 4'h0) begin
            stack_count <= stack_count - 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_overflow <= 1'b0;
        end else if (take && stack_count == 4'(`STACK_DEPTH)) begin
            stack_overflow <= 1'b1;
        end else if (wr_en && paddr == `OFS_CORE_CTRL && pwdata[1]) begin
            stack_overflow <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // entry sequence towards the core

    entry_state_e state_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_RUN;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (take) begin
                        state_reg <= ST_PRE;
                    end
                end
                ST_PRE: begin
                    if (machine_cycle) begin
                        state_reg <= ST_RUN; // RULE14
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_load     <= 1'b0;
            vector_addr     <= '0;
            preprocess_busy <= 1'b0;
            global_mask     <= 1'b0;
        end else begin
            vector_load <= take; // RULE20
            global_mask <= mask_reg;
            if (take) begin
                vector_addr     <= PC_W'({1'b0, winner, 1'b0} + 5'h02); // RULE20 RULE21
                preprocess_busy <= 1'b1; // RULE14
            end else if (state_reg == ST_PRE && machine_cycle) begin
                preprocess_busy <= 1'b0; // RULE14
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restore_load  <= 1'b0;
            restore_pc    <= '0;
            restore_flags <= '0;
        end else begin
            restore_load <= return_instr && stack_count != 4'h0;
            if (return_instr && stack_count != 4'h0) begin
                restore_pc    <= pc_stack[top_idx];
                restore_flags <= pop_flags;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, read data registered with pready

    always_comb begin
        addr_hit = 1'b1;
        rd_word  = 32'h0000_0000;
        if (paddr == `OFS_EDGE_SEL_A) begin
            rd_word[3:0] = edge_sel_a_reg;
        end else if (paddr == `OFS_EDGE_SEL_B) begin
            rd_word[3:0] = edge_sel_b_reg;
        end else if (paddr == `OFS_IRQ_EN_A) begin
            rd_word[3:0] = irq_enable_a_reg;
        end else if (paddr == `OFS_IRQ_EN_B) begin
            rd_word[3:0] = irq_enable_b_reg;
        end else if (paddr == `OFS_IRQ_PEND_A) begin
            rd_word[3:0] = irq_pending_a_reg; // RULE7
        end else if (paddr == `OFS_IRQ_PEND_B) begin
            rd_word[3:0] = irq_pending_b_reg;
        end else if (paddr == `OFS_CORE_CTRL) begin
            rd_word[`CTRL_MASK_BIT] = mask_reg;
            rd_word[1]              = stack_overflow;
            rd_word[`CTRL_DEPTH_LSB +: 4] = stack_count;
        end else begin
            addr_hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd_en;
            pslverr <= rd_en & ~addr_hit;
            if (rd_en) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_word;
            end
        end
    end
endmodule

//--- tb/cpu_core_model.sv
// core model: machine-cycle pacing, program counter and status flags
`timescale 1ns/100ps
module cpu_core_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        slow,
    input  wire logic        vector_load,
    input  wire logic [11:0] vector_addr,
    input  wire logic        restore_load,
    input  wire logic [11:0] restore_pc,
    output logic             machine_cycle,
    output logic      [11:0] core_pc,
    output logic      [3:0]  status_flag_reg
);
    logic [1:0] phase_reg;
    // slow pacing stands for long table reads: two extra cycles per sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 2'h0;
            machine_cycle <= 1'b0;
        end else begin
            phase_reg <= (slow && phase_reg < 2'h2) ? phase_reg + 2'h1 : 2'h0;
            machine_cycle <= (phase_reg == 2'h0);
        end
    end
    // pc moves only on entry and return, so the saved value is unambiguous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            core_pc <= 12'h100;
        else if (vector_load)
            core_pc <= vector_addr;
        else if (restore_load)
            core_pc <= restore_pc;
    end
    assign status_flag_reg = {1'b0, core_pc[3:1]};
endmodule

//--- tb/nibble_mcu_interrupt_ctrl_asserts.sv
// checker: port-level properties of the interrupt controller
`timescale 1ns/100ps
module irq_ctrl_checker #(
    parameter int PC_W = 12
) (
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic            machine_cycle,
    input wire logic            return_instr,
    input wire logic            vector_load,
    input wire logic [PC_W-1:0] vector_addr,
    input wire logic            preprocess_busy,
    input wire logic            restore_load,
    input wire logic            global_mask,
    input wire logic            stack_overflow
);
    logic clr_w;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign clr_w = psel && penable && pready && pwrite && paddr == 12'h018 && pwdata[1];
    ////////////////////////////////////////////////////////////////////////
    property p_wait;
        psel && $rose(penable) |-> !pready ##1 pready;
    endproperty
    a_wait: assert property (p_wait) else $error("ready not after one wait");
    property p_err;
        pslverr |-> pready && (pwrite || prdata == 32'h0);
    endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_cause;
        vector_load |-> $past(machine_cycle) && !$past(preprocess_busy);
    endproperty
    a_cause: assert property (p_cause) else $error("entry off a sample point");
    property p_entry;
        vector_load |-> preprocess_busy ##1 !global_mask;
    endproperty
    a_entry: assert property (p_entry) else $error("entry without busy or mask");
    property p_busy;
        preprocess_busy |=> preprocess_busy == !$past(machine_cycle);
    endproperty
    a_busy: assert property (p_busy) else $error("busy not one machine cycle");
    property p_pulse;
        vector_load |=> !vector_load;
    endproperty
    a_pulse: assert property (p_pulse) else $error("vector load too long");
    property p_vec;
        vector_load |-> !vector_addr[0] && vector_addr >= 2 && vector_addr <= 16;
    endproperty
    a_vec: assert property (p_vec) else $error("vector outside table");
    property p_pop;
        restore_load |-> $past(return_instr);
    endproperty
    a_pop: assert property (p_pop) else $error("restore without return");
    property p_ovf;
        stack_overflow && !clr_w && !$past(clr_w) |=> stack_overflow;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow lost");
    c_entry: cover property (vector_load);
    c_pop: cover property (restore_load);
    c_err: cover property (pslverr);
    c_ovf: cover property (stack_overflow);
endmodule
bind nibble_mcu_interrupt_ctrl irq_ctrl_checker #(.PC_W(PC_W)) u_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .machine_cycle,
    .return_instr, .vector_load, .vector_addr, .preprocess_busy, .restore_load,
    .global_mask, .stack_overflow);

//--- tb/nibble_mcu_interrupt_ctrl_tb_top.sv
// bench: apb driver, core model, reference model and checks
`timescale 1ns/100ps
module nibble_mcu_interrupt_ctrl_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
    logic        ext_pin_zero, ext_pin_one, key_scan_input, machine_cycle, return_instr;
    logic        timer_zero_event, timer_one_event, converter_event, voltage_level_alarm;
    logic        watchdog, mask_set_instr, mask_clear_instr, vector_load, preprocess_busy;
    logic        restore_load, global_mask, stack_overflow;
    logic [2:0]  pin_v, ins;
    logic [4:0]  evs;
    logic [3:0]  status_flag_reg, restore_flags;
    logic [11:0] paddr, core_pc, vector_addr, restore_pc, last_vec, pa;
    logic [31:0] pwdata, prdata, rd, seed, r, bv;
    int          mismatches, check_count, vl_count, cycles, k, j, c, exp_pend;
    logic [11:0] pcq[$];
    logic [3:0]  flq[$];

    assign {key_scan_input, ext_pin_one, ext_pin_zero} = pin_v;
    assign {return_instr, mask_clear_instr, mask_set_instr} = ins;
    assign {watchdog, voltage_level_alarm, converter_event, timer_one_event,
            timer_zero_event} = evs;
    nibble_mcu_interrupt_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_pin_zero, .ext_pin_one, .key_scan_input,
        .timer_zero_event, .timer_one_event, .converter_event, .voltage_level_alarm, .watchdog,
        .machine_cycle, .mask_set_instr, .mask_clear_instr, .return_instr, .core_pc,
        .status_flag_reg, .vector_load, .vector_addr, .preprocess_busy, .restore_load,
        .restore_pc, .restore_flags, .global_mask, .stack_overflow);
    cpu_core_model core (.pclk, .presetn, .slow, .vector_load, .vector_addr, .restore_load,
        .restore_pc, .machine_cycle, .core_pc, .status_flag_reg);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input string w, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(w, e, rd);
    endtask
    task automatic pins(input logic [2:0] v);
        pin_v <= v;
        repeat (5) @(posedge pclk);
    endtask
    task automatic instr(input int w);
        @(posedge pclk);
        ins <= 3'(1 << w);
        @(posedge pclk);
        ins <= 3'h0;
    endtask
    task automatic ev(input logic [4:0] m);
        @(posedge pclk);
        evs <= m;
        @(posedge pclk);
        evs <= 5'h0;
    endtask
    task automatic wait_vl(input int n);
        for (int t = 0; t < 40 && vl_count < n; t++)
            @(negedge pclk);
        chk("accept count", 32'(n), 32'(vl_count));
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reference stacks follow every entry and every return
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            results();
        end
        if (vector_load === 1'b1) begin
            vl_count++;
            last_vec = vector_addr;
            pcq.push_back(core_pc);
            flq.push_back(status_flag_reg | 4'h8);
        end
        if (restore_load === 1'b1 && pcq.size() > 0) begin
            chk("restore pc", 32'(pcq.pop_back()), 32'(restore_pc));
            chk("restore flags", 32'(flq.pop_back()), 32'(restore_flags));
        end
    end
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        seed = 32'hFF04;
        {presetn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
        {pin_v, ins, evs} = '0;
        {mismatches, check_count, vl_count, cycles} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 8; k++)
            rc("reset value", 12'(4 * k), 32'h0);
        chk("unmapped read", 32'h1, {31'h0, err});
        for (k = 0; k < 6; k++) begin
            r = rnd();
            apb(1'b1, 12'(4 * k), r);
            rc("readback", 12'(4 * k), r & 32'hF);
        end
        apb(1'b1, 12'h01C, rnd());
        chk("unmapped write", 32'h1, {31'h0, err});
        $display("registers done");
        for (j = 0; j < 3; j++) begin
            pa = (j == 2) ? 12'h014 : 12'h010;
            bv = (j == 0) ? 32'h1 : 32'h2;
            for (c = 0; c < 4; c++) begin
                apb(1'b1, (j == 2) ? 12'h004 : 12'h000, 32'(c << (2 * (j % 2))));
                apb(1'b1, 12'h010, 32'h0);
                apb(1'b1, 12'h014, 32'h0);
                pins(3'(1 << j));
                rc("rise flag", pa, c[1] ? bv : 32'h0);
                apb(1'b1, pa, 32'h0);
                rc("level held", pa, 32'h0);
                pins(3'h0);
                rc("fall flag", pa, c[0] ? bv : 32'h0);
            end
        end
        chk("masked accept", 32'h0, 32'(vl_count));
        $display("edges done");
        r = rnd();
        slow <= r[0];
        apb(1'b1, 12'h000, 32'hA);
        apb(1'b1, 12'h004, 32'h2);
        apb(1'b1, 12'h008, 32'hE);
        apb(1'b1, 12'h00C, 32'hF);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h014, 32'h0);
        pins(3'h7);
        ev(5'h1F);
        repeat (5) @(posedge pclk);
        rc("pending a", 12'h010, 32'hF);
        rc("pending b", 12'h014, 32'hF);
        exp_pend = 32'hFF;
        // pin zero stays disabled until last, so it must be passed over
        for (k = 0; k < 8; k++) begin
            j = (k < 7) ? k + 1 : 0;
            if (k == 7)
                apb(1'b1, 12'h008, 32'hF);
            instr(0);
            wait_vl(k + 1);
            chk("vector", 32'(2 + 2 * j), 32'(last_vec));
            exp_pend &= ~(1 << j);
            rc("pending a", 12'h010, exp_pend & 32'hF);
            rc("pending b", 12'h014, exp_pend >> 4);
            rc("depth", 12'h018, 32'((k + 1) << 4));
        end
        for (k = 0; k < 8; k++) begin
            instr(2);
            repeat (3) @(posedge pclk);
        end
        chk("stack drained", 32'h0, 32'(pcq.size()));
        rc("mask restored", 12'h018, 32'h1);
        $display("nesting done");
        instr(1);
        repeat (2) @(posedge pclk);
        chk("mask clear", 32'h0, {31'h0, global_mask});
        ev(5'h01);
        repeat (6) @(posedge pclk);
        chk("masked accept", 32'h8, 32'(vl_count));
        instr(0);
        wait_vl(9);
        chk("vector", 32'h6, 32'(last_vec));
        fork
            apb(1'b1, 12'h010, 32'h0);
            begin
                repeat (3) @(posedge pclk);
                evs <= 5'h1;
                @(posedge pclk);
                evs <= 5'h0;
            end
        join
        rc("set beats clear", 12'h010, 32'h4);
        $display("mask done");
        for (k = 0; k < 8; k++) begin
            ev(5'h01);
            instr(0);
            wait_vl(10 + k);
        end
        rc("overflow", 12'h018, 32'h82);
        chk("overflow port", 32'h1, {31'h0, stack_overflow});
        apb(1'b1, 12'h018, 32'h2);
        rc("overflow clear", 12'h018, 32'h80);
        $display("overflow done");
        results();
    end
endmodule
